// ==== logic/srap_defs.svh ====
// What this block does
// - First protocol seen after power-up locks interface
// - Frame spans frame select low to high
// - Host clock may be continuous or gated
// - Device samples input on falling clock edges
// - Host holds select low for 24 falls
// - Short frames discarded with no register effect
// - Readback output disabled after reset
// - Three-wire mode keeps first 24 bits only
// - Select high blocks clock, input; readback released
// - Bit 23 direction, 22-16 index, 15-0 payload
// - Direction 0 writes payload, 1 requests read
// - Reads served only with readback enable set
// - Four-wire needs general pin mapped as readback
// - Host sends second frame to collect read data
// - Next frame echoes direction, index, then data
// - Readback edge chosen by configuration bit
// - Host uses slower clock for readback frames
// - Four-wire: multiples of 24 keep last 24
`ifndef SRAP_DEFS_SVH
`define SRAP_DEFS_SVH

// ----------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------
`define SRAP_FRAME_BITS 24
`define SRAP_CNT_FULL 5'h18
`define SRAP_MOD_LAST 5'h17
`define SRAP_DIR_BIT 23
`define SRAP_IDX_HI 22
`define SRAP_IDX_LO 16
`define SRAP_PAY_HI 15
`define SRAP_TX_FIRST 5'h17
`define SRAP_DIR_WRITE 1'b0
`define SRAP_DIR_READ 1'b1

// ----------------------------------------------------------------
// Device interface configuration register
// ----------------------------------------------------------------
`define SRAP_CFG_IDX 7'h0F
`define SRAP_CFG_RB_EN 0
`define SRAP_CFG_EDGE 1
`define SRAP_CFG_RST 16'h0000

// ----------------------------------------------------------------
// Host controller register map
// ----------------------------------------------------------------
`define SRAP_H_CMD 8'h00
`define SRAP_H_STAT 8'h04
`define SRAP_H_RX 8'h08
`define SRAP_H_DIV 8'h0C
`define SRAP_H_SLOW_BIT 24
`define SRAP_H_HALF_WR_RST 8'h04
`define SRAP_H_HALF_RD_RST 8'h08
`define SRAP_H_GAP 8'h08

`endif

// ==== logic/srap_pkg.sv ====
package srap_pkg;
  // Which host protocol owns the device until reset
  typedef enum logic [1:0] {
    SRAP_PROTO_NONE = 2'b00,
    SRAP_PROTO_SERIAL = 2'b01,
    SRAP_PROTO_OTHER = 2'b10
  } srap_proto_t;

  // Host frame sequencer
  typedef enum logic [1:0] {
    SRAP_HS_IDLE = 2'b00,
    SRAP_HS_HIGH = 2'b01,
    SRAP_HS_LOW = 2'b10,
    SRAP_HS_GAP = 2'b11
  } srap_hstate_t;
endpackage

// ==== logic/srap_if.sv ====
interface srap_if;
  logic sync_b;
  logic sclk;
  logic sdi;
  logic sdo;
  logic sdo_oe;
  logic rb_line;

  // Released readback line idles high
  assign rb_line = sdo_oe ? sdo : 1'b1;

  modport dev (
    input sync_b,
    input sclk,
    input sdi,
    output sdo,
    output sdo_oe
  );

  modport host (
    output sync_b,
    output sclk,
    output sdi,
    input rb_line
  );
endinterface

// ==== logic/srap_device.sv ====
`include "srap_defs.svh"

module srap_device #(
  parameter int IDX_W = 7,
  parameter int DATA_W = 16
) (
  input wire logic core_clk,
  input wire logic rst_b,
  srap_if.dev lnk,
  input wire logic other_proto_seen,
  input wire logic gpio_is_readback,
  input wire logic [IDX_W-1:0] usr_idx,
  output logic [DATA_W-1:0] usr_data,
  output srap_pkg::srap_proto_t proto_sel,
  output logic cmt_pulse,
  output logic [7:0] drop_cnt
);

  // ----------------------------------------------------------------
  // Link domain: capture on the host clock
  // ----------------------------------------------------------------
  logic armed_reg;
  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;
  logic [4:0] mod_reg;
  logic [4:0] mod_next;
  logic [23:0] first_reg;
  logic [23:0] first_next;
  logic [23:0] last_reg;
  logic [4:0] idx_f_reg;
  logic [4:0] idx_r_reg;
  wire [4:0] cnt_base;
  wire [4:0] mod_base;
  wire [23:0] first_base;
  wire [4:0] tx_idx;

  // Restart is armed asynchronously while select is high, since a gated
  // clock gives no edge to clear the counters between frames.
  always_ff @(negedge lnk.sclk or posedge lnk.sync_b) begin
    if (lnk.sync_b) begin
      armed_reg <= 1'b1;
    end else begin
      armed_reg <= 1'b0;
    end
  end

  // Frame counters and shift images seen from the first falling edge
  assign cnt_base = armed_reg ? 5'h00 : cnt_reg;
  assign mod_base = armed_reg ? 5'h00 : mod_reg;
  assign first_base = armed_reg ? 24'h000000 : first_reg;
  assign cnt_next = (cnt_base == `SRAP_CNT_FULL) ? cnt_base : cnt_base + 5'h01;
  assign mod_next = (mod_base == `SRAP_MOD_LAST) ? 5'h00 : mod_base + 5'h01;
  assign first_next = (cnt_base == `SRAP_CNT_FULL) ? first_base :
                      {first_base[22:0], lnk.sdi};

  always_ff @(negedge lnk.sclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= 5'h00;
      mod_reg <= 5'h00;
      first_reg <= 24'h000000;
      last_reg <= 24'h000000;
    end else if (!lnk.sync_b) begin
      cnt_reg <= cnt_next;
      mod_reg <= mod_next;
      first_reg <= first_next;
      last_reg <= {last_reg[22:0], lnk.sdi};
    end
  end

  always_ff @(negedge lnk.sclk or posedge lnk.sync_b) begin
    if (lnk.sync_b) begin
      idx_f_reg <= `SRAP_TX_FIRST;
    end else begin
      idx_f_reg <= (idx_f_reg == 5'h00) ? `SRAP_TX_FIRST : idx_f_reg - 5'h01;
    end
  end

  always_ff @(posedge lnk.sclk or posedge lnk.sync_b) begin
    if (lnk.sync_b) begin
      idx_r_reg <= `SRAP_TX_FIRST;
    end else begin
      idx_r_reg <= (idx_r_reg == 5'h00) ? `SRAP_TX_FIRST : idx_r_reg - 5'h01;
    end
  end

  // ----------------------------------------------------------------
  // Core domain: frame end detection and register space
  // ----------------------------------------------------------------
  logic sy1_reg;
  logic sy2_reg;
  logic sy3_reg;
  logic [DATA_W-1:0] mem [0:(1<<IDX_W)-1];
  logic [DATA_W-1:0] cfg_reg;
  logic [23:0] rb_word_reg;
  logic cmt_reg;
  logic [7:0] drop_reg;
  logic [DATA_W-1:0] usr_data_reg;
  srap_pkg::srap_proto_t proto_reg;
  srap_pkg::srap_proto_t proto_next;
  wire frame_end;
  wire frame_start;
  wire four_wire;
  wire frame_ok;
  wire [23:0] word;
  wire word_dir;
  wire [IDX_W-1:0] word_idx;
  wire [DATA_W-1:0] word_pay;
  wire do_write;

  // Register read path shared by readback and the user port
  function automatic logic [DATA_W-1:0] rd_val(input logic [IDX_W-1:0] idx);
    rd_val = (idx == `SRAP_CFG_IDX) ? cfg_reg : mem[idx];
  endfunction

  // Select is a pin to this domain: two flops, then an edge stage
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sy1_reg <= 1'b1;
      sy2_reg <= 1'b1;
      sy3_reg <= 1'b1;
    end else begin
      sy1_reg <= lnk.sync_b;
      sy2_reg <= sy1_reg;
      sy3_reg <= sy2_reg;
    end
  end

  assign frame_end = sy2_reg & ~sy3_reg;
  assign frame_start = ~sy2_reg & sy3_reg;

  assign proto_next = (proto_reg != srap_pkg::SRAP_PROTO_NONE) ? proto_reg :
                      frame_start ? srap_pkg::SRAP_PROTO_SERIAL :
                      other_proto_seen ? srap_pkg::SRAP_PROTO_OTHER : proto_reg;

  assign four_wire = cfg_reg[`SRAP_CFG_RB_EN] & gpio_is_readback;

  // Link registers are still at frame end: the clock is blocked behind
  // select, so sampling them two core cycles later is safe.
  // short frame rejected
  assign frame_ok = (proto_reg == srap_pkg::SRAP_PROTO_SERIAL) &&
                    (cnt_reg == `SRAP_CNT_FULL) &&
                    (!four_wire || mod_reg == 5'h00);
  assign word = four_wire ? last_reg : first_reg;
  assign word_dir = word[`SRAP_DIR_BIT];
  assign word_idx = word[`SRAP_IDX_HI:`SRAP_IDX_LO];
  assign word_pay = word[`SRAP_PAY_HI:0];
  assign do_write = frame_end && frame_ok && (word_dir == `SRAP_DIR_WRITE);

  // Protocol lock, configuration and status
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      proto_reg <= srap_pkg::SRAP_PROTO_NONE;
      cfg_reg <= `SRAP_CFG_RST;
      cmt_reg <= 1'b0;
      drop_reg <= 8'h00;
    end else begin
      proto_reg <= proto_next;
      cmt_reg <= do_write;
      if (do_write && word_idx == `SRAP_CFG_IDX) begin
        cfg_reg <= word_pay;
      end
      if (frame_end && !frame_ok && drop_reg != 8'hFF) begin
        drop_reg <= drop_reg + 8'h01;
      end
    end
  end

  // Register array has no reset, as a real register file would load defaults
  always_ff @(posedge core_clk) begin
    if (do_write) begin
      mem[word_idx] <= word_pay;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rb_word_reg <= 24'h000000;
    end else if (frame_end && frame_ok && four_wire) begin
      rb_word_reg <= {word[`SRAP_DIR_BIT:`SRAP_IDX_LO],
                      (word_dir == `SRAP_DIR_READ) ? rd_val(word_idx) : word_pay};
    end
  end

  // User read port, one cycle latency
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      usr_data_reg <= '0;
    end else begin
      usr_data_reg <= rd_val(usr_idx);
    end
  end

  // ----------------------------------------------------------------
  // Readback pin
  // ----------------------------------------------------------------
  // The word is held steady while select is low, and the host must leave
  // a gap before the next frame so the core can load it.
  // edge select
  assign tx_idx = cfg_reg[`SRAP_CFG_EDGE] ? idx_r_reg : idx_f_reg;
  assign lnk.sdo = rb_word_reg[tx_idx];
  assign lnk.sdo_oe = ~lnk.sync_b & four_wire;

  assign usr_data = usr_data_reg;
  assign proto_sel = proto_reg;
  assign cmt_pulse = cmt_reg;
  assign drop_cnt = drop_reg;

endmodule

// ==== logic/srap_host.sv ====
`include "srap_defs.svh"

module srap_host (
  input wire logic core_clk,
  input wire logic rst_b,
  srap_if.host lnk,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rdata
);

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  logic [23:0] tx_reg;
  logic [23:0] rx_reg;
  logic [7:0] half_wr_reg;
  logic [7:0] half_rd_reg;
  logic slow_reg;
  logic [31:0] rdata_reg;
  logic busy;
  logic start;
  logic rb1_reg;
  logic rb2_reg;
  logic sync_b_reg;
  logic sclk_reg;
  logic sdi_reg;
  logic [7:0] tmr_reg;
  logic [4:0] bit_reg;
  srap_pkg::srap_hstate_t st_reg;
  wire [7:0] half;
  wire tmr_done;

  assign busy = (st_reg != srap_pkg::SRAP_HS_IDLE);
  assign start = wr_stb && addr == `SRAP_H_CMD && !busy;
  assign half = slow_reg ? half_rd_reg : half_wr_reg;
  assign tmr_done = (tmr_reg == 8'h00);

  // Command and divider writes; a command while busy is dropped
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      half_wr_reg <= `SRAP_H_HALF_WR_RST;
      half_rd_reg <= `SRAP_H_HALF_RD_RST;
      slow_reg <= 1'b0;
    end else if (wr_stb && addr == `SRAP_H_DIV) begin
      half_wr_reg <= wdata[7:0];
      half_rd_reg <= wdata[15:8];
    end else if (start) begin
      slow_reg <= wdata[`SRAP_H_SLOW_BIT] | wdata[`SRAP_DIR_BIT];
    end
  end

  // Read data stand one cycle after the strobe
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= 32'h00000000;
    end else if (rd_stb) begin
      case (addr)
        `SRAP_H_STAT: rdata_reg <= {31'h00000000, busy};
        `SRAP_H_RX: rdata_reg <= {8'h00, rx_reg};
        `SRAP_H_DIV: rdata_reg <= {16'h0000, half_rd_reg, half_wr_reg};
        default: rdata_reg <= 32'h00000000;
      endcase
    end else begin
      rdata_reg <= 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // Frame sequencer with clock divider
  // ----------------------------------------------------------------
  // Readback line from the device is a pin here
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rb1_reg <= 1'b1;
      rb2_reg <= 1'b1;
    end else begin
      rb1_reg <= lnk.rb_line;
      rb2_reg <= rb1_reg;
    end
  end

  // Clock idles high; data change after rising, device samples falling.
  // 24 falling edges
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= srap_pkg::SRAP_HS_IDLE;
      sync_b_reg <= 1'b1;
      sclk_reg <= 1'b1;
      sdi_reg <= 1'b0;
      tx_reg <= 24'h000000;
      rx_reg <= 24'h000000;
      tmr_reg <= 8'h00;
      bit_reg <= 5'h00;
    end else begin
      case (st_reg)
        srap_pkg::SRAP_HS_IDLE: begin
          if (start) begin
            st_reg <= srap_pkg::SRAP_HS_HIGH;
            sync_b_reg <= 1'b0;
            tx_reg <= wdata[23:0];
            sdi_reg <= wdata[`SRAP_DIR_BIT];
            tmr_reg <= half;
            bit_reg <= 5'h00;
          end
        end
        srap_pkg::SRAP_HS_HIGH: begin
          if (tmr_done) begin
            st_reg <= srap_pkg::SRAP_HS_LOW;
            sclk_reg <= 1'b0;
            rx_reg <= {rx_reg[22:0], rb2_reg};
            tmr_reg <= half;
            bit_reg <= bit_reg + 5'h01;
          end else begin
            tmr_reg <= tmr_reg - 8'h01;
          end
        end
        srap_pkg::SRAP_HS_LOW: begin
          if (tmr_done) begin
            sclk_reg <= 1'b1;
            tmr_reg <= half;
            if (bit_reg == `SRAP_CNT_FULL) begin
              st_reg <= srap_pkg::SRAP_HS_GAP;
            end else begin
              st_reg <= srap_pkg::SRAP_HS_HIGH;
              tx_reg <= {tx_reg[22:0], 1'b0};
              sdi_reg <= tx_reg[22];
            end
          end else begin
            tmr_reg <= tmr_reg - 8'h01;
          end
        end
        srap_pkg::SRAP_HS_GAP: begin
          // Leaves the device time to commit before the next frame
          if (tmr_done) begin
            if (sync_b_reg) begin
              st_reg <= srap_pkg::SRAP_HS_IDLE;
            end else begin
              sync_b_reg <= 1'b1;
              tmr_reg <= `SRAP_H_GAP;
            end
          end else begin
            tmr_reg <= tmr_reg - 8'h01;
          end
        end
        default: st_reg <= srap_pkg::SRAP_HS_IDLE;
      endcase
    end
  end

  assign lnk.sync_b = sync_b_reg;
  assign lnk.sclk = sclk_reg;
  assign lnk.sdi = sdi_reg;
  assign rdata = rdata_reg;

endmodule

// ==== sim/srap_link_checker.sv ====
module srap_link_checker (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic sync_b,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic rb_line
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [5:0] fall_reg;
  logic [5:0] fall_next;
  logic sclk_reg;

  // ------------------------------------------------------------
  // Falling serial edges seen in the current frame
  // ------------------------------------------------------------
  assign fall_next = sync_b ? 6'h00 : fall_reg + {5'h00, sclk_reg & ~sclk};
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fall_reg <= 6'h00;
      sclk_reg <= 1'b1;
    end else begin
      fall_reg <= fall_next;
      sclk_reg <= sclk;
    end
  end

  // Frame opening: select drops, clock must wait before its first fall
  sequence frame_open_s;
    $fell(sync_b);
  endsequence
  sequence clock_quiet_s;
    sclk [*4];
  endsequence

  frame_start_a: assert property (
    @(posedge core_clk) disable iff (!rst_b) frame_open_s |-> clock_quiet_s)
    else $error("serial clock fell too soon after frame open");
  frame_gap_a: assert property (
    @(posedge core_clk) disable iff (!rst_b) $rose(sync_b) |-> sync_b [*8])
    else $error("frame select gap too short");
  clock_idle_a: assert property (
    @(posedge core_clk) disable iff (!rst_b) sync_b |-> sclk)
    else $error("serial clock not idle high outside a frame");
  fall_in_frame_a: assert property (
    @(negedge sclk) disable iff (!rst_b) !sync_b)
    else $error("serial clock fell outside a frame");
  data_stable_a: assert property (
    @(posedge core_clk) disable iff (!rst_b) $fell(sclk) |-> $stable(sdi))
    else $error("serial input moved at a falling clock");
  frame_len_a: assert property (
    @(posedge core_clk) disable iff (!rst_b) $rose(sync_b) |-> fall_reg == 6'h18)
    else $error("frame did not carry 24 falling edges");
  readback_off_a: assert property (
    @(posedge core_clk) disable iff (!rst_b) sync_b |-> !sdo_oe)
    else $error("readback driven while select high");
  // Inside a frame the readback bit may only move right after a serial edge
  readback_line_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    !sync_b && !$past(sync_b) && ($changed(sdo) || $changed(rb_line)) |-> $changed(sclk))
    else $error("readback bit moved away from a serial clock edge");
  // Mode changes land only between frames, never halfway through one
  readback_mode_a: assert property (
    @(posedge core_clk) disable iff (!rst_b) !sync_b && !$past(sync_b) |-> $stable(sdo_oe))
    else $error("readback enable changed inside a frame");
endmodule

// ==== sim/tb.sv ====
`include "srap_defs.svh"

module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [31:0] rdata;
  logic oth_a = 1'b0;
  logic oth_b = 1'b0;
  logic gp_a = 1'b0;
  logic gp_b = 1'b0;
  logic [6:0] idx_a = 7'h00;
  logic [6:0] idx_b = 7'h00;
  logic [15:0] dat_a;
  logic [15:0] dat_b;
  srap_pkg::srap_proto_t pr_a;
  srap_pkg::srap_proto_t pr_b;
  logic cm_a;
  logic [7:0] dr_a;
  logic [7:0] dr_b;
  int errors = 0;
  int checked = 0;
  int cmts = 0;
  logic run_clk = 1'b0;
  logic [31:0] r;
  logic [15:0] p;
  logic [15:0] d16;
  logic [6:0] i;

  // ------------------------------------------------------------
  // Host and device joined; second device faces the bench driver
  // ------------------------------------------------------------
  srap_if lnk_a ();
  srap_if lnk_b ();
  srap_host u_srap_host (.core_clk(core_clk), .rst_b(rst_b), .lnk(lnk_a), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata));
  srap_device u_srap_device (.core_clk(core_clk), .rst_b(rst_b), .lnk(lnk_a),
    .other_proto_seen(oth_a), .gpio_is_readback(gp_a), .usr_idx(idx_a), .usr_data(dat_a),
    .proto_sel(pr_a), .cmt_pulse(cm_a), .drop_cnt(dr_a));
  srap_device u_srap_device_b (.core_clk(core_clk), .rst_b(rst_b), .lnk(lnk_b),
    .other_proto_seen(oth_b), .gpio_is_readback(gp_b), .usr_idx(idx_b), .usr_data(dat_b),
    .proto_sel(pr_b), .cmt_pulse(), .drop_cnt(dr_b));
  srap_link_checker u_srap_link_checker (.core_clk(core_clk), .rst_b(rst_b),
    .sync_b(lnk_a.sync_b), .sclk(lnk_a.sclk), .sdi(lnk_a.sdi), .sdo(lnk_a.sdo),
    .sdo_oe(lnk_a.sdo_oe), .rb_line(lnk_a.rb_line));

  // Clock and commit pulse tally
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (cm_a === 1'b1) cmts++;
  end

  function automatic logic [23:0] fr(input logic d, input logic [6:0] x,
                                     input logic [15:0] v);
    return {d, x, v};
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wrap_up();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Register port cycles
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge core_clk);
    wr_stb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask

  // Busy poll is bounded so a stuck sequencer ends the run
  task automatic xfer(input logic [23:0] f, input logic slow);
    logic [31:0] s;
    wr(`SRAP_H_CMD, {7'h00, slow, f});
    for (int k = 0; k < 400; k++) begin
      rd(`SRAP_H_STAT, s);
      if (s[0] === 1'b0) return;
    end
    errors++;
    wrap_up();
  endtask

  task automatic peek(input bit b, input logic [6:0] x, output logic [15:0] d);
    @(posedge core_clk);
    if (b) idx_b <= x;
    else idx_a <= x;
    @(posedge core_clk);
    #1 d = b ? dat_b : dat_a;
  endtask

  // Bench-made link clock, 48 ns, gated or free-running; released data inverted
  task automatic bb(input int n, input logic [47:0] w);
    lnk_b.sync_b = 1'b0;
    for (int k = n - 1; k >= 0; k--) begin
      lnk_b.sdi = w[k];
      #24 lnk_b.sclk = 1'b0;
      #24 lnk_b.sclk = 1'b1;
    end
    #24 lnk_b.sync_b = 1'b1;
    lnk_b.sdi = ~lnk_b.sdi;
    // clock left running between frames; select must block it
    if (run_clk) begin
      repeat (3) begin
        #24 lnk_b.sclk = 1'b0;
        #24 lnk_b.sclk = 1'b1;
      end
      // Keeps the next select fall away from a rising clock
      #24;
    end else begin
      #100;
    end
  endtask

  initial begin
    lnk_b.sync_b = 1'b1;
    lnk_b.sclk = 1'b1;
    lnk_b.sdi = 1'b0;
    r = $urandom(95221);
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    #1 chk({pr_a, dr_a, lnk_a.sdo_oe, lnk_a.sync_b, lnk_a.sclk}, 32'h00000003);
    rd(`SRAP_H_DIV, r);
    chk(r, {16'h0000, `SRAP_H_HALF_RD_RST, `SRAP_H_HALF_WR_RST});
    wr(`SRAP_H_DIV, 32'h00000A03);
    rd(`SRAP_H_DIV, r);
    chk(r, 32'h00000A03);
    $display("reset test done");
    for (int k = 0; k < 8; k++) begin
      i = (k == 0) ? 7'h7F : (k == 1) ? 7'h00 : 7'($urandom_range(126, 32));
      p = (k == 0) ? 16'hFFFF : 16'($urandom);
      xfer(fr(`SRAP_DIR_WRITE, i, p), 1'b0);
      peek(1'b0, i, d16);
      chk(d16, p);
    end
    chk(cmts, 8);
    $display("write test done");
    @(posedge core_clk) oth_a <= 1'b1;
    @(posedge core_clk) oth_a <= 1'b0;
    xfer(fr(`SRAP_DIR_READ, i, 16'h0000), 1'b1);
    xfer(fr(`SRAP_DIR_READ, i, 16'h0000), 1'b1);
    rd(`SRAP_H_RX, r);
    chk(r[23:0], 24'hFFFFFF);
    chk(pr_a, srap_pkg::SRAP_PROTO_SERIAL);
    $display("three-wire read test done");
    @(posedge core_clk) gp_a <= 1'b1;
    for (int e = 0; e < 2; e++) begin
      xfer(fr(`SRAP_DIR_WRITE, `SRAP_CFG_IDX, 16'(e * 2 + 1)), 1'b0);
      xfer(fr(`SRAP_DIR_READ, i, 16'h0000), 1'b1);
      xfer(fr(`SRAP_DIR_WRITE, 7'h10 + 7'(e), ~p), 1'b1);
      rd(`SRAP_H_RX, r);
      chk(r[23:0], fr(`SRAP_DIR_READ, i, p));
      xfer(fr(`SRAP_DIR_READ, i, 16'h0000), 1'b1);
      rd(`SRAP_H_RX, r);
      chk(r[23:0], fr(`SRAP_DIR_WRITE, 7'h10 + 7'(e), ~p));
    end
    @(posedge core_clk) gp_a <= 1'b0;
    xfer(fr(`SRAP_DIR_READ, i, 16'h0000), 1'b1);
    xfer(fr(`SRAP_DIR_READ, i, 16'h0000), 1'b1);
    rd(`SRAP_H_RX, r);
    chk(r[23:0], 24'hFFFFFF);
    $display("four-wire read test done");
    bb(24, 48'(fr(1'b0, 7'h05, 16'h1234)));
    bb(20, 48'(fr(1'b0, 7'h05, 16'hBEEF) >> 4));
    peek(1'b1, 7'h05, d16);
    chk({dr_b, d16}, {8'h01, 16'h1234});
    bb(30, 48'({fr(1'b0, 7'h05, 16'h5A5A), 6'($urandom)}));
    peek(1'b1, 7'h05, d16);
    chk(d16, 16'h5A5A);
    run_clk = 1'b1;
    bb(24, 48'(fr(1'b0, 7'h07, p)));
    bb(24, 48'(fr(1'b0, 7'h07, ~p)));
    run_clk = 1'b0;
    peek(1'b1, 7'h07, d16);
    chk({dr_b, d16}, {8'h01, ~p});
    @(posedge core_clk) gp_b <= 1'b1;
    bb(24, 48'(fr(1'b0, `SRAP_CFG_IDX, 16'h0001)));
    bb(48, {fr(1'b0, 7'h06, 16'h1111), fr(1'b0, 7'h06, 16'h2222)});
    bb(30, 48'({fr(1'b0, 7'h06, 16'h3333), 6'h15}));
    peek(1'b1, 7'h06, d16);
    chk({dr_b, d16}, {8'h02, 16'h2222});
    $display("link fault test done");
    @(posedge core_clk) rst_b <= 1'b0;
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    oth_b <= 1'b1;
    @(posedge core_clk) oth_b <= 1'b0;
    bb(24, 48'(fr(1'b0, 7'h08, 16'h0F0F)));
    chk({pr_b, dr_b}, {srap_pkg::SRAP_PROTO_OTHER, 8'h01});
    $display("protocol lock test done");
    wrap_up();
  end
endmodule
